// file: design/ihc_core.sv
// I/O hold/clear bridge core with start-up parameter batch read
`timescale 1ns/1ps
module ihc_core
    import ihc_pkg::*;
#(
    parameter int NB = IHC_NB,
    parameter int NW = IHC_NW,
    parameter int WW = IHC_WW,
    parameter int NS = IHC_NS
) (
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire ihc_apb_req_s       apb_req,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               link_up,
    input  wire logic [2:0]         cpu_state,
    input  wire logic               dev_error,
    input  wire logic               remote_reset,
    input  wire logic [NB-1:0]      slave_bit_in,
    input  wire logic [NB-1:0]      slave_bit_lost,
    input  wire logic [NW*WW-1:0]   slave_word_in,
    input  wire logic [NW-1:0]      slave_word_lost,
    input  wire logic [NS-1:0]      slave_registered,
    output logic [NB-1:0]           slave_bit_out,
    output logic [NW*WW-1:0]        slave_word_out,
    output logic                    par_req,
    output logic [$clog2(NS)-1:0]   par_id,
    input  wire logic               par_ack,
    input  wire logic [31:0]        par_data
);
    localparam int IW = $clog2(NS);
    localparam int PW = 3 + 3 + 2 * NB + NW * WW + NW + NS;

    // Sizes the decode cannot serve are refused
    if (NB < 1 || NB > 32 || WW < 1 || WW > 32 || NW < 1 || NW > 4 || NS < 2 || NS > 16) begin
        $error("ihc_core: unsupported size parameters");
    end

    typedef struct packed {
        logic [31:0]              prdata;
        logic                     pready;
        logic                     pslverr;
        logic [3:0]               ctrl;
        logic [NB-1:0]            bit_reg;
        logic [NW-1:0][WW-1:0]    word_reg;
        logic [NB-1:0]            bit_out;
        logic [NW-1:0][WW-1:0]    word_out;
        logic [NB-1:0]            bit_in;
        logic [NW-1:0][WW-1:0]    word_in;
        logic                     live;
        logic                     rr_prev;
        logic                     pending;
        ihc_batch_e               bstate;
        logic [IW-1:0]            idx;
        logic                     req;
        logic [NS-1:0][31:0]      pmem;
    } ihc_state_s;

    ihc_state_s st_q;
    ihc_state_s st_d;

    // Pins from the far side pass two flops first
    logic [PW-1:0] pins_s;
    ihc_sync #(.W(PW)) ihc_sync_i (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .d       ({link_up, dev_error, remote_reset, cpu_state, slave_bit_in, slave_bit_lost,
                   slave_word_in, slave_word_lost, slave_registered}),
        .q       (pins_s)
    );

    logic                  link_s;
    logic                  err_s;
    logic                  rr_s;
    logic [2:0]            cpu_s; // Raw code, so unused codes read back as sent
    logic [NB-1:0]         bin_s;
    logic [NB-1:0]         blost_s;
    logic [NW-1:0][WW-1:0] win_s;
    logic [NW-1:0]         wlost_s;
    logic [NS-1:0]         reg_s;
    assign {link_s, err_s, rr_s, cpu_s, bin_s, blost_s, win_s, wlost_s, reg_s} = pins_s;

    // Settings steering the data path
    logic out_hold;
    logic win_hold;
    logic start_mode;
    logic locked;
    assign out_hold   = st_q.ctrl[IHC_CTRL_OUT_HOLD];
    assign win_hold   = st_q.ctrl[IHC_CTRL_WIN_HOLD];
    assign start_mode = st_q.ctrl[IHC_CTRL_START_MODE];
    assign locked     = st_q.ctrl[IHC_CTRL_LOCK];

    // Outputs track the master only while linked and the CPU runs or pauses
    logic live_now;
    assign live_now = link_s
                      && (cpu_s == IHC_CPU_RUN || cpu_s == IHC_CPU_PAUSE);

    // Per-word input path: lost word slave clears or holds
    logic [NW-1:0][WW-1:0] win_next;
    for (genvar g = 0; g < NW; g++) begin : g_win
        assign win_next[g] = wlost_s[g] ? (win_hold ? st_q.word_in[g] : '0) : win_s[g];
    end

    // Register read decode
    function automatic logic [32:0] rd_word(input ihc_state_s s, input logic [7:0] a,
                                            input logic [31:0] stat);
        logic [32:0] r;
        r = {1'b1, 32'h0000_0000};
        if (a == IHC_OFF_CTRL) begin
            r = {1'b0, 28'h000_0000, s.ctrl};
        end else if (a == IHC_OFF_STATUS) begin
            r = {1'b0, stat};
        end else if (a == IHC_OFF_BIT_OUT) begin
            r = {1'b0, 32'(s.bit_reg)};
        end else if (a == IHC_OFF_BIT_IN) begin
            r = {1'b0, 32'(s.bit_in)};
        end else if (a >= IHC_OFF_WORD_OUT && a < IHC_OFF_WORD_OUT + IHC_OFF_BANK_SZ) begin
            if (a[3:2] < NW && a[1:0] == 2'h0) begin
                r = {1'b0, 32'(s.word_reg[a[3:2]])};
            end
        end else if (a >= IHC_OFF_WORD_IN && a < IHC_OFF_WORD_IN + IHC_OFF_BANK_SZ) begin
            if (a[3:2] < NW && a[1:0] == 2'h0) begin
                r = {1'b0, 32'(s.word_in[a[3:2]])};
            end
        end else if (a >= IHC_OFF_PMEM && a < IHC_OFF_PMEM + IHC_OFF_PMEM_SZ) begin
            if (a[5:2] < NS && a[1:0] == 2'h0) begin
                r = {1'b0, s.pmem[a[5:2]]};
            end
        end
        return r;
    endfunction

    logic [31:0] status_w;
    always_comb begin
        status_w = 32'h0000_0000;
        status_w[IHC_ST_LINK]          = link_s;
        status_w[IHC_ST_DEVERR]        = err_s;
        status_w[IHC_ST_CPU +: 3]      = cpu_s;
        status_w[IHC_ST_LIVE]          = st_q.live;
        status_w[IHC_ST_BUSY]          = (st_q.bstate == IHC_B_SCAN || st_q.bstate == IHC_B_WAIT);
        status_w[IHC_ST_DONE]          = (st_q.bstate == IHC_B_DONE);
    end

    logic setup_c;
    logic wr_c;
    logic [32:0] rd_c;
    assign setup_c = apb_req.psel && !apb_req.penable;
    assign wr_c    = apb_req.psel && apb_req.penable && st_q.pready && apb_req.pwrite
                     && !st_q.pslverr;
    assign rd_c    = rd_word(st_q, apb_req.paddr, status_w);

    // Next-state logic
    always_comb begin
        st_d = st_q;
        // APB: answer registered in setup, ready in first access cycle
        st_d.pready  = setup_c;
        st_d.pslverr = setup_c ? (rd_c[32] || (apb_req.pwrite
                       && apb_req.paddr == IHC_OFF_STATUS)) : 1'b0;
        st_d.prdata  = (setup_c && !apb_req.pwrite) ? rd_c[31:0] : 32'h0000_0000;
        if (wr_c) begin
            if (apb_req.paddr == IHC_OFF_CTRL && !locked) begin
                st_d.ctrl = apb_req.pwdata[3:0];
            end else if (apb_req.paddr == IHC_OFF_BIT_OUT) begin
                st_d.bit_reg = apb_req.pwdata[NB-1:0];
            end else if (apb_req.paddr[7:4] == IHC_OFF_WORD_OUT[7:4]) begin
                st_d.word_reg[apb_req.paddr[3:2]] = apb_req.pwdata[WW-1:0];
            end
        end

        // Output path
        st_d.live = live_now && !err_s;
        if (err_s) begin
            st_d.bit_out  = '0;
            st_d.word_out = '0;
        end else if (live_now) begin
            st_d.bit_out  = st_q.bit_reg;
            st_d.word_out = st_q.word_reg;
        end else if (!out_hold) begin
            st_d.bit_out  = '0;
            st_d.word_out = '0;
        end else begin
            st_d.bit_out  = st_q.bit_out;
            st_d.word_out = st_q.word_out;
        end

        // Input path
        if (err_s) begin
            st_d.bit_in  = '0;
            st_d.word_in = '0;
        end else begin
            st_d.bit_in  = bin_s & ~blost_s;
            st_d.word_in = win_next;
        end

        // Remote reset re-arms the start-up read like a power cycle
        st_d.rr_prev = rr_s;
        if (rr_s && !st_q.rr_prev) begin
            st_d.pending = 1'b1;
            st_d.bstate  = IHC_B_IDLE;
            st_d.req     = 1'b0;
        end else begin
            case (st_q.bstate)
                IHC_B_IDLE: begin
                    // Settings must be locked so the mode cannot change mid-read
                    if (st_q.pending && locked) begin
                        if (!start_mode) begin
                            st_d.pending = 1'b0;
                        end else if (link_s && !err_s) begin
                            st_d.pending = 1'b0;
                            st_d.idx     = '0;
                            st_d.bstate  = IHC_B_SCAN;
                        end
                    end
                end
                IHC_B_SCAN: begin
                    if (!link_s || err_s) begin
                        st_d.pending = 1'b1;
                        st_d.bstate  = IHC_B_IDLE;
                    end else if (reg_s[st_q.idx]) begin
                        st_d.req    = 1'b1;
                        st_d.bstate = IHC_B_WAIT;
                    end else if (st_q.idx == IW'(NS - 1)) begin
                        st_d.bstate = IHC_B_DONE;
                    end else begin
                        st_d.idx = st_q.idx + 1'b1;
                    end
                end
                IHC_B_WAIT: begin
                    if (par_ack) begin
                        st_d.req            = 1'b0;
                        st_d.pmem[st_q.idx] = par_data;
                        if (st_q.idx == IW'(NS - 1)) begin
                            st_d.bstate = IHC_B_DONE;
                        end else begin
                            st_d.idx    = st_q.idx + 1'b1;
                            st_d.bstate = IHC_B_SCAN;
                        end
                    end else if (!link_s || err_s) begin
                        // Abandon and retry once communication is back
                        st_d.req     = 1'b0;
                        st_d.pending = 1'b1;
                        st_d.bstate  = IHC_B_IDLE;
                    end
                end
                IHC_B_DONE: begin
                    st_d.bstate = IHC_B_DONE;
                end
                default: begin
                    st_d.bstate = IHC_B_IDLE;
                end
            endcase
        end
    end

    // State register; a reset counts as a power cycle for the start-up read
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_q         <= '0;
            st_q.ctrl    <= IHC_CTRL_RESET;
            st_q.pending <= 1'b1;
            st_q.bstate  <= IHC_B_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata         = st_q.prdata;
    assign pready         = st_q.pready;
    assign pslverr        = st_q.pslverr;
    assign slave_bit_out  = st_q.bit_out;
    assign slave_word_out = st_q.word_out;
    assign par_req        = st_q.req;
    assign par_id         = st_q.idx;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic stopped_c;
    assign stopped_c = !live_now && !err_s;

    a_error_all_off: assert property (err_s |=> slave_bit_out == '0
        && slave_word_out == '0 && st_q.bit_in == '0)
        else $error("I/O not off on device error");
    a_live_drive_out: assert property (live_now && !err_s |=>
        slave_bit_out == $past(st_q.bit_reg) && slave_word_out == $past(st_q.word_reg))
        else $error("outputs not following");
    a_clear_outputs: assert property (stopped_c && !out_hold |=>
        slave_bit_out == '0 && slave_word_out == '0) else $error("outputs not cleared");
    a_hold_outputs: assert property (stopped_c && out_hold |=>
        $stable(slave_bit_out) && $stable(slave_word_out)) else $error("outputs not held");
    a_link_down_stop: assert property (!link_s |=> !st_q.live)
        else $error("live while link down");
    a_bit_in_path: assert property (!err_s |=>
        (st_q.bit_in & ~$past(blost_s)) == ($past(bin_s) & ~$past(blost_s)))
        else $error("bit input not stored");
    a_lost_bit_zero: assert property (1'b1 |=> (st_q.bit_in & $past(blost_s)) == '0)
        else $error("lost bit not zero");
    a_req_registered: assert property (par_req |->
        reg_s[par_id] || $past(reg_s[par_id])) else $error("request to unregistered slave");
    a_pmem_store: assert property (st_q.bstate == IHC_B_WAIT && par_ack |=>
        st_q.pmem[$past(st_q.idx)] == $past(par_data)) else $error("param not stored");
    a_mode_gates_req: assert property (par_req |-> start_mode && locked)
        else $error("batch read without start-up mode");
    a_cfg_locked: assert property (locked |=> $stable(st_q.ctrl))
        else $error("settings changed after lock");

    c_batch_done: cover property (st_q.bstate == IHC_B_WAIT ##1 st_q.bstate == IHC_B_DONE);
    c_hold_engaged: cover property (live_now && !err_s ##1 stopped_c && out_hold);
    c_word_hold: cover property (wlost_s[0] && win_hold && !err_s);
    c_error_off: cover property (live_now ##1 err_s);
endmodule

// file: design/ihc_pkg.sv
// Package with constants and carrier types for the I/O hold/clear block
package ihc_pkg;
    // Register byte offsets
    localparam logic [7:0] IHC_OFF_CTRL     = 8'h00;
    localparam logic [7:0] IHC_OFF_STATUS   = 8'h04;
    localparam logic [7:0] IHC_OFF_BIT_OUT  = 8'h08;
    localparam logic [7:0] IHC_OFF_BIT_IN   = 8'h0c;
    localparam logic [7:0] IHC_OFF_WORD_OUT = 8'h10;
    localparam logic [7:0] IHC_OFF_WORD_IN  = 8'h20;
    localparam logic [7:0] IHC_OFF_PMEM     = 8'h40;
    localparam logic [7:0] IHC_OFF_BANK_SZ  = 8'h10;
    localparam logic [7:0] IHC_OFF_PMEM_SZ  = 8'h40;

    // Control register fields
    localparam int IHC_CTRL_OUT_HOLD   = 0;
    localparam int IHC_CTRL_WIN_HOLD   = 1;
    localparam int IHC_CTRL_START_MODE = 2;
    localparam int IHC_CTRL_LOCK       = 3;
    localparam logic [3:0] IHC_CTRL_RESET = 4'h0;

    // Status register fields
    localparam int IHC_ST_LINK   = 0;
    localparam int IHC_ST_DEVERR = 1;
    localparam int IHC_ST_CPU    = 2;
    localparam int IHC_ST_LIVE   = 5;
    localparam int IHC_ST_BUSY   = 6;
    localparam int IHC_ST_DONE   = 7;

    // Default sizes
    localparam int IHC_NB = 16;
    localparam int IHC_NW = 2;
    localparam int IHC_WW = 16;
    localparam int IHC_NS = 8;

    // CPU run state as reported by the master station
    typedef enum logic [2:0] {
        IHC_CPU_RUN     = 3'b000,
        IHC_CPU_STOP    = 3'b001,
        IHC_CPU_PAUSE   = 3'b010,
        IHC_CPU_RESET   = 3'b011,
        IHC_CPU_ERRSTOP = 3'b100
    } ihc_cpu_e;

    // Start-up batch read sequencer
    typedef enum logic [2:0] {
        IHC_B_IDLE = 3'b000,
        IHC_B_SCAN = 3'b001,
        IHC_B_WAIT = 3'b010,
        IHC_B_DONE = 3'b011
    } ihc_batch_e;

    // APB request bundle from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ihc_apb_req_s;
endpackage

// file: design/ihc_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module ihc_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } ihc_sync_s;

    ihc_sync_s st_q;
    ihc_sync_s st_d;

    // First stage feeds only the second stage
    always_comb begin
        st_d.meta   = d;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.stable;
endmodule

// file: test/ihc_par_model.sv
// Far-side responder for start-up parameter reads
`timescale 1ns/1ps
module ihc_par_model #(
    parameter int IW = 3
) (
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    input  wire logic          par_req,
    input  wire logic [IW-1:0] par_id,
    output logic               par_ack,
    output logic [31:0]        par_data
);
    int wait_q;

    // Odd ids answer slowly, even ids at once; one word per slave
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wait_q   <= 0;
            par_ack  <= 1'b0;
            par_data <= 32'h0;
        end else if (par_req && !par_ack) begin
            if (wait_q >= (par_id[0] ? 6 : 0)) begin
                par_ack  <= 1'b1;
                par_data <= {16'hc3a5, {(16 - IW){1'b0}}, par_id};
                wait_q   <= 0;
            end else begin
                wait_q <= wait_q + 1;
            end
        end else begin
            par_ack  <= 1'b0;
            par_data <= ~par_data; // Not valid outside ack, so keep it moving
        end
    end
endmodule

// file: test/io_hold_clear_startup_read_tb_top.sv
// Self-checking bench for the hold/clear core over APB
`timescale 1ns/1ps
module io_hold_clear_startup_read_tb_top
    import ihc_pkg::*;
;
    localparam logic [31:0] WEXP = 32'hbeef1234;
    logic         sys_clk;
    logic         rst_n;
    ihc_apb_req_s req;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         link_up;
    logic [2:0]   cpu_state;
    logic         dev_error;
    logic         remote_reset;
    logic [15:0]  bit_in;
    logic [15:0]  bit_lost;
    logic [15:0]  bit_out;
    logic [31:0]  word_in;
    logic [31:0]  word_out;
    logic [1:0]   word_lost;
    logic [7:0]   regd;
    logic         par_req;
    logic         par_ack;
    logic [2:0]   par_id;
    logic [31:0]  par_data;
    logic [31:0]  rd;
    logic         err;
    int           mismatches;
    int           samples_checked;
    int           cycles;
    int           acks;
    ihc_cpu_e     st [5] = '{IHC_CPU_RUN, IHC_CPU_STOP, IHC_CPU_PAUSE, IHC_CPU_RESET,
                             IHC_CPU_ERRSTOP};

    ihc_core ihc_core_i (.sys_clk(sys_clk), .rst_n(rst_n), .apb_req(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_up(link_up), .cpu_state(cpu_state),
        .dev_error(dev_error), .remote_reset(remote_reset), .slave_bit_in(bit_in),
        .slave_bit_lost(bit_lost), .slave_word_in(word_in), .slave_word_lost(word_lost),
        .slave_registered(regd), .slave_bit_out(bit_out), .slave_word_out(word_out),
        .par_req(par_req), .par_id(par_id), .par_ack(par_ack), .par_data(par_data));
    ihc_par_model ihc_par_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .par_req(par_req),
        .par_id(par_id), .par_ack(par_ack), .par_data(par_data));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Hang guard, and a tally of answered parameter reads
    always @(posedge sys_clk) begin
        cycles++;
        if (par_ack === 1'b1) acks++;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end

    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; only the hang guard ends a wait for pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        req <= '0;
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk(32'(err), 32'(e));
    endtask

    // Pins pass two synchroniser flops before they act
    task settle;
        repeat (6) @(posedge sys_clk);
    endtask

    task do_reset;
        rst_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        acks = 0;
    endtask

    task out_chk(input logic [15:0] b, input logic [31:0] w);
        chk(32'(bit_out), 32'(b));
        chk(word_out, w);
    endtask

    task set_outs;
        apb(1'b1, IHC_OFF_BIT_OUT, 32'ha5c3);
        apb(1'b1, IHC_OFF_WORD_OUT, 32'h1234);
        apb(1'b1, IHC_OFF_WORD_OUT + 8'h04, 32'hbeef);
    endtask

    // Every CPU state, then link loss
    task out_pass(input logic hold);
        logic live;
        for (int i = 0; i < 5; i++) begin
            cpu_state <= st[i];
            settle();
            live = (st[i] == IHC_CPU_RUN) || (st[i] == IHC_CPU_PAUSE);
            out_chk(live || hold ? 16'ha5c3 : 16'h0,
                    live || hold ? WEXP : 32'h0);
        end
        cpu_state <= IHC_CPU_RUN;
        link_up <= 1'b0;
        settle();
        out_chk(hold ? 16'ha5c3 : 16'h0, hold ? WEXP : 32'h0);
    endtask

    // Lost bits read 0; lost words clear or hold
    task in_pass(input logic hold);
        bit_in <= 16'hf0f0;
        bit_lost <= 16'h0ff0;
        word_in <= 32'h5555aaaa;
        word_lost <= 2'b00;
        settle();
        rd_chk(IHC_OFF_BIT_IN, 32'hf000, 1'b0);
        rd_chk(IHC_OFF_WORD_IN, 32'haaaa, 1'b0);
        word_lost <= 2'b01;
        word_in <= 32'h55551111;
        settle();
        rd_chk(IHC_OFF_WORD_IN, hold ? 32'haaaa : 32'h0, 1'b0);
        rd_chk(IHC_OFF_WORD_IN + 8'h04, 32'h5555, 1'b0);
    endtask

    initial begin
        rst_n = 1'b0;
        req = '0;
        link_up = 1'b1;
        cpu_state = IHC_CPU_RUN;
        dev_error = 1'b0;
        remote_reset = 1'b0;
        bit_in = 16'h0;
        bit_lost = 16'h0;
        word_in = 32'h0;
        word_lost = 2'b00;
        regd = 8'ha5;
        mismatches = 0;
        samples_checked = 0;
        cycles = 0;
        acks = 0;
        do_reset();
        // Register access and refusals
        rd_chk(IHC_OFF_CTRL, 32'h0, 1'b0);
        rd_chk(8'h30, 32'h0, 1'b1);
        apb(1'b1, IHC_OFF_STATUS, 32'hff);
        chk(32'(err), 32'h1);
        $display("test regs done");
        // Batch read waits for the lock, then reads registered slaves
        apb(1'b1, IHC_OFF_CTRL, 32'h4);
        settle();
        chk(acks, 0);
        apb(1'b1, IHC_OFF_CTRL, 32'hc);
        for (int n = 0; n < 400 && acks < 4; n++) @(posedge sys_clk);
        settle();
        chk(acks, 4);
        rd_chk(IHC_OFF_STATUS, 32'ha1, 1'b0);
        for (int n = 0; n < 8; n++) begin
            rd_chk(IHC_OFF_PMEM + 8'(4 * n),
                   regd[n] ? {16'hc3a5, 13'h0, 3'(n)} : 32'h0, 1'b0);
        end
        apb(1'b1, IHC_OFF_CTRL, 32'h3);
        rd_chk(IHC_OFF_CTRL, 32'hc, 1'b0);
        // Remote reset with the link down: the read must wait for the link
        link_up <= 1'b0;
        remote_reset <= 1'b1;
        settle();
        chk(acks, 4);
        link_up <= 1'b1;
        for (int n = 0; n < 400 && acks < 8; n++) @(posedge sys_clk);
        chk(acks, 8);
        remote_reset <= 1'b0;
        $display("test batch done");
        // Clear setting
        set_outs();
        out_pass(1'b0);
        link_up <= 1'b1;
        in_pass(1'b0);
        $display("test clear done");
        // Hold setting, start-up read disabled
        do_reset();
        apb(1'b1, IHC_OFF_CTRL, 32'hb);
        settle();
        chk(acks, 0);
        rd_chk(IHC_OFF_PMEM, 32'h0, 1'b0);
        set_outs();
        out_pass(1'b1);
        apb(1'b1, IHC_OFF_BIT_OUT, 32'h0f0f);
        settle();
        out_chk(16'ha5c3, WEXP);
        link_up <= 1'b1;
        settle();
        out_chk(16'h0f0f, WEXP);
        in_pass(1'b1);
        dev_error <= 1'b1;
        settle();
        out_chk(16'h0, 32'h0);
        rd_chk(IHC_OFF_BIT_IN, 32'h0, 1'b0);
        $display("test hold done");
        wrap_up();
    end
endmodule
